/* File: src/cpcnt_defs.svh */
// Register numbers, selects, field positions and reset values of the counter and resume-PC bank
`ifndef CPCNT_DEFS_SVH
`define CPCNT_DEFS_SVH

`define CPCNT_REGNUM_PERF 5'h19
`define CPCNT_REGNUM_ERRPC 5'h1e
`define CPCNT_SEL_CTL_ZERO 3'h0
`define CPCNT_SEL_CNT_ZERO 3'h1
`define CPCNT_SEL_CTL_ONE 3'h2
`define CPCNT_SEL_CNT_ONE 3'h3
`define CPCNT_SEL_ERRPC 3'h0
`define CPCNT_CTL_EN_BIT 0
`define CPCNT_CTL_EN_RESET 1'h0
`define CPCNT_ISA_RESET 2'h0
`define CPCNT_RESET_VECTOR 32'hbfc0_0000
`define CPCNT_DATA_ZERO 32'h0000_0000

`endif

/* File: src/cpcnt_pkg.sv */
// Types shared by the counter and resume-PC bank
package cpcnt_pkg;
    typedef enum logic [1:0] {
        CPCNT_EXC_ERROR,
        CPCNT_EXC_SOFT_RESET,
        CPCNT_EXC_NMI,
        CPCNT_EXC_OTHER
    } cpcnt_exc_t;
endpackage : cpcnt_pkg

/* File: src/cpcnt_cnt_if.sv */
// Link between the bank and one event counter
`timescale 1ns/10ps
`default_nettype none
interface cpcnt_cnt_if;
    logic load;
    logic [31:0] load_data;
    logic enable;
    logic event_hit;
    logic [31:0] count;
    modport ctrl (output load, output load_data, output enable, output event_hit, input count);
    modport cnt (input load, input load_data, input enable, input event_hit, output count);
endinterface : cpcnt_cnt_if
`default_nettype wire

/* File: src/cpcnt_counter.sv */
// One 32-bit event counter with software load
`timescale 1ns/10ps
`default_nettype none
module cpcnt_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control and count
    cpcnt_cnt_if.cnt link
);
    logic [31:0] count;

    // Count has no reset value; a write wins over an event in the same cycle
    always_ff @(posedge clk) begin
        if (link.load) begin
            count <= link.load_data;
        end else if (link.enable && link.event_hit) begin
            count <= count + 32'h0000_0001;
        end
    end

    assign link.count = count;

    a_count_step:
    assert property (@(posedge clk) disable iff (sys_rst)
        (!link.load && link.enable && link.event_hit) |=> (count == $past(count) + 32'h0000_0001))
        else $error("counter did not step by one on an enabled event");

    a_count_hold:
    assert property (@(posedge clk) disable iff (sys_rst)
        (!link.load && !(link.enable && link.event_hit)) |=> $stable(count))
        else $error("counter moved without an enabled event");

    a_count_load:
    assert property (@(posedge clk) disable iff (sys_rst)
        link.load |=> (count == $past(link.load_data)))
        else $error("software write did not replace the count");

    c_count_wrap:
    cover property (@(posedge clk) disable iff (sys_rst)
        (link.enable && link.event_hit && !link.load && count == 32'hffff_ffff) ##1 (count == 32'h0000_0000));
endmodule : cpcnt_counter
`default_nettype wire

/* File: src/cpcnt_top.sv */
// Event counters and error resume-PC slice of the system coprocessor
// How it works
// - Two counters, two controls, register 25
// - Select field picks the register-25 entry
// - Counters idle after reset until enabled
// - Count registers are full 32-bit read/write
// - Resume PC at register 30 select 0
// - Capture resume PC on error, soft reset, NMI
// - Error capture uses faulting instruction address
// - Delay slot fault captures preceding branch address
// - No delay-slot flag is stored
// - Read returns PC upper bits plus mode bit
// - Write loads PC upper bits, bit zero cleared
// - Write clears mode upper bit, loads lower
`timescale 1ns/10ps
`default_nettype none
`include "cpcnt_defs.svh"
module cpcnt_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Coprocessor move access from the core
    input wire logic cop_read,
    input wire logic cop_write,
    input wire logic [4:0] cop_regnum,
    input wire logic [2:0] cop_sel,
    input wire logic [31:0] cop_wdata,
    output var logic [31:0] cop_rdata,
    output var logic cop_rvalid,
    // Event pulses from the pipeline
    input wire logic event_zero_hit,
    input wire logic event_one_hit,
    // Exception entry
    input wire logic exc_take,
    input wire cpcnt_pkg::cpcnt_exc_t exc_kind,
    input wire logic [31:0] exc_pc,
    input wire logic exc_in_slot,
    input wire logic [31:0] exc_branch_pc,
    // Instruction-set mode field
    output var logic [1:0] instruction_set_mode
);
    cpcnt_cnt_if link_zero ();
    cpcnt_cnt_if link_one ();

    logic counter_control_zero;
    logic counter_control_one;
    logic [31:0] error_resume_pc;
    logic sel_perf;
    logic sel_errpc;
    logic capture;
    logic [31:0] capture_pc;
    logic [31:0] next_rdata;

    // Register decode on number, then select
    assign sel_perf = (cop_regnum == `CPCNT_REGNUM_PERF);
    assign sel_errpc = (cop_regnum == `CPCNT_REGNUM_ERRPC) && (cop_sel == `CPCNT_SEL_ERRPC);

    // Error, soft reset and NMI entries all land in the resume PC
    assign capture = exc_take && (exc_kind != cpcnt_pkg::CPCNT_EXC_OTHER);
    // Delay-slot faults resume at the branch so it re-executes; no slot flag kept
    assign capture_pc = exc_in_slot ? exc_branch_pc : exc_pc;

    // Counter controls: only the enable bit is held; event choice lives elsewhere
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counter_control_zero <= `CPCNT_CTL_EN_RESET;
            counter_control_one <= `CPCNT_CTL_EN_RESET;
        end else if (cop_write && sel_perf) begin
            if (cop_sel == `CPCNT_SEL_CTL_ZERO) begin
                counter_control_zero <= cop_wdata[`CPCNT_CTL_EN_BIT];
            end else if (cop_sel == `CPCNT_SEL_CTL_ONE) begin
                counter_control_one <= cop_wdata[`CPCNT_CTL_EN_BIT];
            end
        end
    end

    // Counter hookup
    assign link_zero.load = cop_write && sel_perf && (cop_sel == `CPCNT_SEL_CNT_ZERO);
    assign link_zero.load_data = cop_wdata;
    assign link_zero.enable = counter_control_zero;
    assign link_zero.event_hit = event_zero_hit;
    assign link_one.load = cop_write && sel_perf && (cop_sel == `CPCNT_SEL_CNT_ONE);
    assign link_one.load_data = cop_wdata;
    assign link_one.enable = counter_control_one;
    assign link_one.event_hit = event_one_hit;

    cpcnt_counter u_count_zero (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(link_zero.cnt)
    );

    cpcnt_counter u_count_one (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(link_one.cnt)
    );

    // Resume PC: hard reset loads the vector; an exception beats a write in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            error_resume_pc <= `CPCNT_RESET_VECTOR;
        end else if (capture) begin
            error_resume_pc <= capture_pc;
        end else if (cop_write && sel_errpc) begin
            error_resume_pc <= {cop_wdata[31:1], 1'b0};
        end
    end

    // Mode field: a resume-PC write rewrites it as 0 plus the written low bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            instruction_set_mode <= `CPCNT_ISA_RESET;
        end else if (cop_write && sel_errpc && !capture) begin
            instruction_set_mode <= {1'b0, cop_wdata[0]};
        end
    end

    // Read mux; unmapped numbers and selects read as zero
    always_comb begin
        next_rdata = `CPCNT_DATA_ZERO;
        if (sel_errpc) begin
            next_rdata = {error_resume_pc[31:1], instruction_set_mode[0]};
        end else if (sel_perf && cop_sel == `CPCNT_SEL_CTL_ZERO) begin
            next_rdata[`CPCNT_CTL_EN_BIT] = counter_control_zero;
        end else if (sel_perf && cop_sel == `CPCNT_SEL_CNT_ZERO) begin
            next_rdata = link_zero.count;
        end else if (sel_perf && cop_sel == `CPCNT_SEL_CTL_ONE) begin
            next_rdata[`CPCNT_CTL_EN_BIT] = counter_control_one;
        end else if (sel_perf && cop_sel == `CPCNT_SEL_CNT_ONE) begin
            next_rdata = link_one.count;
        end
    end

    // Read data registered one cycle after the request; held until the next read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cop_rdata <= `CPCNT_DATA_ZERO;
            cop_rvalid <= 1'b0;
        end else begin
            cop_rvalid <= cop_read;
            if (cop_read) begin
                cop_rdata <= next_rdata;
            end
        end
    end

    a_reset_vector:
    assert property (@(posedge clk) sys_rst |=> (error_resume_pc == `CPCNT_RESET_VECTOR))
        else $error("reset did not load the resume PC");

    a_reset_idle:
    assert property (@(posedge clk) sys_rst |=> (!counter_control_zero && !counter_control_one))
        else $error("counter enabled straight out of reset");

    a_capture_fault:
    assert property (@(posedge clk) disable iff (sys_rst)
        (capture && !exc_in_slot) |=> (error_resume_pc == $past(exc_pc)))
        else $error("fault address not captured");

    a_capture_slot:
    assert property (@(posedge clk) disable iff (sys_rst)
        (capture && exc_in_slot) |=> (error_resume_pc == $past(exc_branch_pc)))
        else $error("delay-slot fault did not capture branch address");

    a_pc_write:
    assert property (@(posedge clk) disable iff (sys_rst)
        (cop_write && sel_errpc && !capture) |=> (error_resume_pc == {$past(cop_wdata[31:1]), 1'b0}))
        else $error("resume PC write wrong");

    a_mode_write:
    assert property (@(posedge clk) disable iff (sys_rst)
        (cop_write && sel_errpc && !capture) |=> (instruction_set_mode == {1'b0, $past(cop_wdata[0])}))
        else $error("mode field not set by resume PC write");

    a_read_pc:
    assert property (@(posedge clk) disable iff (sys_rst)
        (cop_read && sel_errpc) |=> (cop_rvalid && cop_rdata == {$past(error_resume_pc[31:1]),
        $past(instruction_set_mode[0])}))
        else $error("resume PC read value wrong");

    a_read_count:
    assert property (@(posedge clk) disable iff (sys_rst)
        (cop_read && sel_perf && cop_sel == `CPCNT_SEL_CNT_ONE) |=> (cop_rdata == $past(link_one.count)))
        else $error("select 3 did not return counter one");

    a_pc_hold:
    assert property (@(posedge clk) disable iff (sys_rst)
        (!capture && !(cop_write && sel_errpc)) |=> $stable(error_resume_pc))
        else $error("resume PC changed with no cause");

    // A capture drops a same-cycle resume-PC write, so the mode must not move either
    a_capture_mode:
    assert property (@(posedge clk) disable iff (sys_rst)
        capture |=> $stable(instruction_set_mode))
        else $error("exception entry disturbed the mode field");

    a_ctl_write:
    assert property (@(posedge clk) disable iff (sys_rst)
        (cop_write && sel_perf && cop_sel == `CPCNT_SEL_CTL_ZERO) |=>
        (counter_control_zero == $past(cop_wdata[`CPCNT_CTL_EN_BIT])))
        else $error("control zero write did not set the enable");

    a_read_ctl:
    assert property (@(posedge clk) disable iff (sys_rst)
        (cop_read && sel_perf && cop_sel == `CPCNT_SEL_CTL_ONE) |=>
        (cop_rdata == {31'h0, $past(counter_control_one)}))
        else $error("select 2 did not return control one");

    a_read_cnt_zero:
    assert property (@(posedge clk) disable iff (sys_rst)
        (cop_read && sel_perf && cop_sel == `CPCNT_SEL_CNT_ZERO) |=> (cop_rdata == $past(link_zero.count)))
        else $error("select 1 did not return counter zero");

    // Valid only ever follows a read request
    a_rvalid_pulse:
    assert property (@(posedge clk) disable iff (sys_rst)
        !cop_read |=> !cop_rvalid)
        else $error("read valid without a read request");

    c_nmi_capture:
    cover property (@(posedge clk) disable iff (sys_rst) exc_take && exc_kind == cpcnt_pkg::CPCNT_EXC_NMI);

    c_enable_count:
    cover property (@(posedge clk) disable iff (sys_rst) counter_control_zero && event_zero_hit);

    c_write_read:
    cover property (@(posedge clk) disable iff (sys_rst) (cop_write && sel_errpc) ##1 (cop_read && sel_errpc));
endmodule : cpcnt_top
`default_nettype wire

/* File: test/cpcnt_core_model.sv */
// Core model that issues coprocessor moves and exception entries
`timescale 1ns/10ps
`default_nettype none
module cpcnt_core_model (
    // Clock
    input wire logic clk,
    // Coprocessor move access
    output logic cop_read,
    output logic cop_write,
    output logic [4:0] cop_regnum,
    output logic [2:0] cop_sel,
    output logic [31:0] cop_wdata,
    input wire logic [31:0] cop_rdata,
    input wire logic cop_rvalid,
    // Exception entry
    output logic exc_take,
    output cpcnt_pkg::cpcnt_exc_t exc_kind,
    output logic [31:0] exc_pc,
    output logic exc_in_slot,
    output logic [31:0] exc_branch_pc
);
    // Idle values at time zero
    initial begin
        cop_read = 1'h0;
        cop_write = 1'h0;
        cop_regnum = 5'h00;
        cop_sel = 3'h0;
        cop_wdata = 32'h0000_0000;
        exc_take = 1'h0;
        exc_kind = cpcnt_pkg::CPCNT_EXC_OTHER;
        exc_pc = 32'h0000_0000;
        exc_in_slot = 1'h0;
        exc_branch_pc = 32'h0000_0000;
    end

    // One move held for one edge; released data shows the inverse so a stale latch is caught
    task automatic move(input logic wr, input logic [4:0] rn, input logic [2:0] sl, input logic [31:0] d);
        @(posedge clk);
        cop_write <= wr;
        cop_read <= ~wr;
        cop_regnum <= rn;
        cop_sel <= sl;
        cop_wdata <= d;
        @(posedge clk);
        cop_write <= 1'h0;
        cop_read <= 1'h0;
        cop_wdata <= ~d;
    endtask : move

    // Read: the answer is sampled at the edge after the request was taken
    task automatic rd(input logic [4:0] rn, input logic [2:0] sl, output logic [31:0] d, output logic v);
        move(1'h0, rn, sl, 32'h0000_0000);
        @(posedge clk);
        d = cop_rdata;
        v = cop_rvalid;
    endtask : rd

    // Exception entry pulse with its addresses
    task automatic enter(input cpcnt_pkg::cpcnt_exc_t k, input logic s, input logic [31:0] p, input logic [31:0] b);
        @(posedge clk);
        exc_take <= 1'h1;
        exc_kind <= k;
        exc_in_slot <= s;
        exc_pc <= p;
        exc_branch_pc <= b;
        @(posedge clk);
        exc_take <= 1'h0;
        exc_pc <= ~p;
        exc_branch_pc <= ~b;
    endtask : enter
endmodule : cpcnt_core_model
`default_nettype wire

/* File: test/cpcnt_top_tb.sv */
// Self-checking bench for the counter and resume-PC bank
`timescale 1ns/10ps
`default_nettype none
module cpcnt_top_tb;
    logic clk, sys_rst, cop_read, cop_write, cop_rvalid, event_zero_hit, event_one_hit, exc_take, exc_in_slot;
    logic [4:0] cop_regnum;
    logic [2:0] cop_sel;
    logic [31:0] cop_wdata, cop_rdata, exc_pc, exc_branch_pc, d, p, b, e;
    logic [1:0] instruction_set_mode;
    logic v;
    cpcnt_pkg::cpcnt_exc_t exc_kind;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    cpcnt_top cpcnt_top_i (.clk, .sys_rst, .cop_read, .cop_write, .cop_regnum, .cop_sel, .cop_wdata,
        .cop_rdata, .cop_rvalid, .event_zero_hit, .event_one_hit, .exc_take, .exc_kind, .exc_pc,
        .exc_in_slot, .exc_branch_pc, .instruction_set_mode);
    cpcnt_core_model cpcnt_core_model_i (.clk, .cop_read, .cop_write, .cop_regnum, .cop_sel, .cop_wdata,
        .cop_rdata, .cop_rvalid, .exc_take, .exc_kind, .exc_pc, .exc_in_slot, .exc_branch_pc);

    // Clock, 10 ns period
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Hang guard: the tests need well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Read through the core model and check both the valid pulse and the data
    task automatic rchk(input logic [4:0] rn, input logic [2:0] sl, input logic [31:0] exp);
        cpcnt_core_model_i.rd(rn, sl, d, v);
        chk({31'h0, v}, 32'h1);
        chk(d, exp);
    endtask : rchk

    task automatic wr(input logic [4:0] rn, input logic [2:0] sl, input logic [31:0] w);
        cpcnt_core_model_i.move(1'h1, rn, sl, w);
    endtask : wr

    task automatic conclude();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        sys_rst = 1'h1;
        event_zero_hit = 1'h0;
        event_one_hit = 1'h0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        // Reset: vector captured, counters disabled, mode cleared
        rchk(5'h1e, 3'h0, 32'hbfc0_0000);
        rchk(5'h19, 3'h0, 32'h0000_0000);
        rchk(5'h19, 3'h2, 32'h0000_0000);
        chk({30'h0, instruction_set_mode}, 32'h0000_0000);
        $display("test reset done");
        // Counts load, hold while disabled, then counter zero counts and wraps
        wr(5'h19, 3'h1, 32'hffff_fffe);
        wr(5'h19, 3'h3, 32'h0000_1234);
        event_zero_hit <= 1'h1;
        event_one_hit <= 1'h1;
        repeat (4) @(posedge clk);
        event_zero_hit <= 1'h0;
        rchk(5'h19, 3'h1, 32'hffff_fffe);
        wr(5'h19, 3'h0, 32'h0000_0001);
        @(posedge clk);
        event_zero_hit <= 1'h1;
        repeat (3) @(posedge clk);
        event_zero_hit <= 1'h0;
        event_one_hit <= 1'h0;
        rchk(5'h19, 3'h0, 32'h0000_0001);
        wr(5'h19, 3'h0, 32'h0000_0000);
        rchk(5'h19, 3'h1, 32'h0000_0001);
        rchk(5'h19, 3'h3, 32'h0000_1234);
        // Counter one: two counted cycles, then a write that lands on an event cycle
        wr(5'h19, 3'h2, 32'h0000_0001);
        event_one_hit <= 1'h1;
        repeat (2) @(posedge clk);
        event_one_hit <= 1'h0;
        rchk(5'h19, 3'h3, 32'h0000_1236);
        event_one_hit <= 1'h1;
        wr(5'h19, 3'h3, 32'h0000_0100);
        event_one_hit <= 1'h0;
        rchk(5'h19, 3'h3, 32'h0000_0100);
        wr(5'h19, 3'h2, 32'h0000_0000);
        rchk(5'h19, 3'h2, 32'h0000_0000);
        rchk(5'h19, 3'h5, 32'h0000_0000);
        $display("test counters done");
        // Resume PC write and read with mode bit folding
        wr(5'h1e, 3'h0, 32'h1234_5678);
        rchk(5'h1e, 3'h0, 32'h1234_5678);
        chk({30'h0, instruction_set_mode}, 32'h0000_0000);
        wr(5'h1e, 3'h0, 32'h8000_1235);
        rchk(5'h1e, 3'h0, 32'h8000_1235);
        chk({30'h0, instruction_set_mode}, 32'h0000_0001);
        $display("test resume pc done");
        // Every exception kind, alternating delay slot; the last kind must not capture
        e = 32'h8000_1235;
        for (int k = 0; k < 4; k++) begin
            p = 32'h1000_0040 + k * 4;
            b = 32'h2000_0020 + k;
            cpcnt_core_model_i.enter(cpcnt_pkg::cpcnt_exc_t'(k), k[0], p, b);
            if (k < 3) begin
                e = (k[0] ? b : p) | 32'h0000_0001;
            end
            rchk(5'h1e, 3'h0, e);
            chk({30'h0, instruction_set_mode}, 32'h0000_0001);
        end
        // Capture and resume-PC write in one cycle: the capture wins, mode untouched
        fork
            cpcnt_core_model_i.enter(cpcnt_pkg::CPCNT_EXC_ERROR, 1'h0, 32'h3000_0010, 32'h4000_0000);
            wr(5'h1e, 3'h0, 32'h0000_0000);
        join
        rchk(5'h1e, 3'h0, 32'h3000_0011);
        chk({30'h0, instruction_set_mode}, 32'h0000_0001);
        $display("test exceptions done");
        // Reset in mid-run reloads the vector and clears mode and the counter-zero enable
        sys_rst <= 1'h1;
        @(posedge clk);
        sys_rst <= 1'h0;
        rchk(5'h1e, 3'h0, 32'hbfc0_0000);
        rchk(5'h19, 3'h0, 32'h0000_0000);
        chk({30'h0, instruction_set_mode}, 32'h0000_0000);
        $display("test mid reset done");
        conclude();
    end
endmodule : cpcnt_top_tb
`default_nettype wire
